// ===== hw/exec_params.svh
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH
// Data path widths
`define DATA_W      8
`define PROG_W      16
`define PROG_ADDR_W 13
`define DMEM_ADDR_W 8
// Final program page: upper address bits all ones
`define LAST_PAGE_HI 5'h1F
// Reset values
`define ACC_RST  8'h00
`define TABLE_HIGH_LATCH_RST 8'h00
`endif

// ===== hw/exec_pkg.sv
package exec_pkg;
    // Operation select decoded by the core front end
    typedef enum logic [3:0] {
        OP_NOP          = 4'h0,
        OP_SWAP_ACC     = 4'h1,
        OP_SKIP_ZERO    = 4'h2,
        OP_COPY_SKIP    = 4'h3,
        OP_BIT_SKIP     = 4'h4,
        OP_TABLE_PAGED  = 4'h5,
        OP_TABLE_FINAL  = 4'h6,
        OP_XOR_ACC      = 4'h7,
        OP_XOR_MEM      = 4'h8,
        OP_XOR_IMM      = 4'h9
    } op_type;
    // Execute sequencer states
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_DUMMY = 2'b01,
        ST_TABLE = 2'b10
    } state_type;
endpackage : exec_pkg

// ===== hw/skip_table_xor_exec.sv
// Function
// - Swap nibbles of byte into accumulator
// - Skip next instruction when byte is zero
// - Conditional skips take two instruction cycles
// - Copy byte to accumulator, skip if zero
// - Skip when selected bit reads zero
// - Paged table read via high and low pointers
// - Final page table read via low pointer
// - XOR into accumulator, update zero flag
// - XOR into memory, update zero flag
// - XOR immediate into accumulator, zero flag
`include "exec_params.svh"
module skip_table_xor_exec (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rstn,
    // Decoded instruction from fetch stage
    input  wire logic                        instr_valid,
    input  wire exec_pkg::op_type            instr_op,
    input  wire logic [2:0]                  instr_bit,
    input  wire logic [`DATA_W-1:0]          instr_imm,
    input  wire logic [`DMEM_ADDR_W-1:0]     instr_addr,
    input  wire logic                        has_high_ptr,
    // Data memory read data for instr_addr
    input  wire logic [`DATA_W-1:0]          mem_rdata,
    // Table pointers from the core
    input  wire logic [`DATA_W-1:0]          table_pointer_low,
    input  wire logic [`DATA_W-1:0]          table_pointer_high,
    // Program memory read port
    output logic                             prog_req,
    output logic [`PROG_ADDR_W-1:0]          prog_addr,
    input  wire logic [`PROG_W-1:0]          prog_rdata,
    // Data memory write port
    output logic                             mem_we,
    output logic [`DMEM_ADDR_W-1:0]          mem_waddr,
    output logic [`DATA_W-1:0]               mem_wdata,
    // Pipeline control
    output logic                             instr_ready,
    output logic                             pc_advance,
    // Architectural state
    output logic [`DATA_W-1:0]               accumulator,
    output logic [`DATA_W-1:0]               table_high_latch,
    output logic                             zero_flag
);

    // Sequencer state
    exec_pkg::state_type            state_r,   state_nxt;
    // Accumulator and flag
    logic [`DATA_W-1:0]             acc_r,     acc_nxt;
    logic                           z_r,       z_nxt;
    // Table-high latch
    logic [`DATA_W-1:0]             table_high_latch_r,    table_high_latch_nxt;
    // Pending skip: next fetched instruction is dropped
    logic                           skip_r,    skip_nxt;
    // Memory write outputs
    logic                           we_r,      we_nxt;
    logic [`DMEM_ADDR_W-1:0]        waddr_r,   waddr_nxt;
    logic [`DATA_W-1:0]             wdata_r,   wdata_nxt;
    // Program read outputs
    logic                           preq_r,    preq_nxt;
    logic [`PROG_ADDR_W-1:0]        paddr_r,   paddr_nxt;
    // Destination for table low byte
    logic [`DMEM_ADDR_W-1:0]        tdst_r,    tdst_nxt;
    // Wait flag: program memory answers one cycle after the request
    logic                           twait_r,   twait_nxt;
    // Pulses of pipeline progress
    logic                           adv_r,     adv_nxt;
    // Shared XOR result
    logic [`DATA_W-1:0]             xor_mem;
    logic [`DATA_W-1:0]             xor_imm;

    assign xor_mem = acc_r ^ mem_rdata;
    assign xor_imm = acc_r ^ instr_imm;

    // Execute sequencer: next-state and data path
    always_comb begin
        state_nxt = state_r;
        acc_nxt   = acc_r;
        z_nxt     = z_r;
        table_high_latch_nxt  = table_high_latch_r;
        skip_nxt  = skip_r;
        we_nxt    = 1'b0;
        waddr_nxt = waddr_r;
        wdata_nxt = wdata_r;
        preq_nxt  = 1'b0;
        paddr_nxt = paddr_r;
        tdst_nxt  = tdst_r;
        twait_nxt = twait_r;
        adv_nxt   = 1'b0;
        case (state_r)
            exec_pkg::ST_RUN: begin
                if (instr_valid && skip_r) begin
                    // Skipped instruction: PC moves on, nothing written
                    skip_nxt  = 1'b0;
                    adv_nxt   = 1'b1;
                    state_nxt = exec_pkg::ST_DUMMY;
                end else if (instr_valid) begin
                    adv_nxt = 1'b1;
                    case (instr_op)
                        exec_pkg::OP_SWAP_ACC: begin
                            acc_nxt = {mem_rdata[3:0], mem_rdata[7:4]};
                        end
                        exec_pkg::OP_SKIP_ZERO: begin
                            skip_nxt = (mem_rdata == 8'h00);
                        end
                        exec_pkg::OP_COPY_SKIP: begin
                            acc_nxt  = mem_rdata;
                            skip_nxt = (mem_rdata == 8'h00);
                        end
                        exec_pkg::OP_BIT_SKIP: begin
                            skip_nxt = ~mem_rdata[instr_bit];
                        end
                        exec_pkg::OP_TABLE_PAGED: begin
                            // High pointer supplies upper bits when present
                            preq_nxt  = 1'b1;
                            paddr_nxt = has_high_ptr ?
                                {table_pointer_high[4:0], table_pointer_low} :
                                {5'h00, table_pointer_low};
                            tdst_nxt  = instr_addr;
                            // Spend one cycle waiting for the word
                            twait_nxt = 1'b1;
                            adv_nxt   = 1'b0;
                            state_nxt = exec_pkg::ST_TABLE;
                        end
                        exec_pkg::OP_TABLE_FINAL: begin
                            preq_nxt  = 1'b1;
                            paddr_nxt = {`LAST_PAGE_HI, table_pointer_low};
                            tdst_nxt  = instr_addr;
                            // Spend one cycle waiting for the word
                            twait_nxt = 1'b1;
                            adv_nxt   = 1'b0;
                            state_nxt = exec_pkg::ST_TABLE;
                        end
                        exec_pkg::OP_XOR_ACC: begin
                            acc_nxt = xor_mem;
                            z_nxt   = (xor_mem == 8'h00);
                        end
                        exec_pkg::OP_XOR_MEM: begin
                            we_nxt    = 1'b1;
                            waddr_nxt = instr_addr;
                            wdata_nxt = xor_mem;
                            z_nxt     = (xor_mem == 8'h00);
                        end
                        exec_pkg::OP_XOR_IMM: begin
                            acc_nxt = xor_imm;
                            z_nxt   = (xor_imm == 8'h00);
                        end
                        default: begin
                            // Other opcodes belong to other units
                        end
                    endcase
                end
            end
            exec_pkg::ST_DUMMY: begin
                // Dummy cycle completes the two-cycle skip
                // Fetch stage holds the next instruction meanwhile
                state_nxt = exec_pkg::ST_RUN;
            end
            exec_pkg::ST_TABLE: begin
                if (twait_r) begin
                    // Request cycle: the word is not back yet
                    twait_nxt = 1'b0;
                end else begin
                    // Program word returns: low to memory, high to latch
                    we_nxt    = 1'b1;
                    waddr_nxt = tdst_r;
                    wdata_nxt = prog_rdata[7:0];
                    table_high_latch_nxt  = prog_rdata[15:8];
                    adv_nxt   = 1'b1;
                    state_nxt = exec_pkg::ST_RUN;
                end
            end
            default: begin
                state_nxt = exec_pkg::ST_RUN;
            end
        endcase
    end

    // Register all state
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r <= exec_pkg::ST_RUN;
            acc_r   <= `ACC_RST;
            z_r     <= 1'b0;
            table_high_latch_r  <= `TABLE_HIGH_LATCH_RST;
            skip_r  <= 1'b0;
            we_r    <= 1'b0;
            waddr_r <= 8'h00;
            wdata_r <= 8'h00;
            preq_r  <= 1'b0;
            paddr_r <= 13'h0000;
            tdst_r  <= 8'h00;
            twait_r <= 1'b0;
            adv_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            acc_r   <= acc_nxt;
            z_r     <= z_nxt;
            table_high_latch_r  <= table_high_latch_nxt;
            skip_r  <= skip_nxt;
            we_r    <= we_nxt;
            waddr_r <= waddr_nxt;
            wdata_r <= wdata_nxt;
            preq_r  <= preq_nxt;
            paddr_r <= paddr_nxt;
            tdst_r  <= tdst_nxt;
            twait_r <= twait_nxt;
            adv_r   <= adv_nxt;
        end
    end

    // Instructions accepted only in the run state
    assign instr_ready      = (state_r == exec_pkg::ST_RUN);
    // Everything below leaves straight from a register
    assign pc_advance       = adv_r;
    assign prog_req         = preq_r;
    assign prog_addr        = paddr_r;
    assign mem_we           = we_r;
    assign mem_waddr        = waddr_r;
    assign mem_wdata        = wdata_r;
    assign accumulator      = acc_r;
    assign table_high_latch = table_high_latch_r;
    assign zero_flag        = z_r;

endmodule : skip_table_xor_exec

// ===== testbench/skip_table_xor_exec_props.sv
`include "exec_params.svh"
module skip_table_xor_exec_props (
    // Clock and reset
    input wire logic                     clk,
    input wire logic                     rstn,
    // Instruction side
    input wire logic                     instr_valid,
    input wire exec_pkg::op_type         instr_op,
    input wire logic [2:0]               instr_bit,
    input wire logic [`DATA_W-1:0]      instr_imm,
    input wire logic [`DATA_W-1:0]      mem_rdata,
    input wire logic [`DATA_W-1:0]      table_pointer_low,
    // Results
    input wire logic                     instr_ready,
    input wire logic                     prog_req,
    input wire logic [`PROG_ADDR_W-1:0] prog_addr,
    input wire logic                     mem_we,
    input wire logic [`DATA_W-1:0]      mem_wdata,
    input wire logic [`DATA_W-1:0]      accumulator,
    input wire logic                     zero_flag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // Skip owed by the last executed instruction: the next one taken is dropped
    logic                   pend_r;
    // Accepted, executed and skip-setting instruction helpers
    wire logic              take = instr_valid && instr_ready;
    wire logic              exec = take && !pend_r;
    wire logic              zero_m = mem_rdata == 8'h00;
    wire logic              zskip = exec && zero_m && instr_op == exec_pkg::OP_SKIP_ZERO;
    wire logic              skip_set = exec && ((zero_m && instr_op inside
        {exec_pkg::OP_SKIP_ZERO, exec_pkg::OP_COPY_SKIP}) ||
        (instr_op == exec_pkg::OP_BIT_SKIP && !mem_rdata[instr_bit]));
    wire logic [7:0]        swapped = {mem_rdata[3:0], mem_rdata[7:4]};
    wire logic [7:0]        xor_m = accumulator ^ mem_rdata;
    wire logic [7:0]        xor_i = accumulator ^ instr_imm;
    wire logic              tbl = instr_op inside
        {exec_pkg::OP_TABLE_PAGED, exec_pkg::OP_TABLE_FINAL};
    // Track the owed skip from the instruction stream alone
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pend_r <= 1'b0;
        end else if (take) begin
            pend_r <= skip_set;
        end
    end
    a_swap_nibbles: assert property (exec && instr_op == exec_pkg::OP_SWAP_ACC |=>
        accumulator == $past(swapped) && $stable(zero_flag)) else $error("swap result wrong");
    a_skip_dummy: assert property (
        zskip ##1 take |=> !instr_ready ##1 instr_ready)
        else $error("skip dummy cycle wrong");
    a_skip_nowrite: assert property (
        zskip ##1 take |=> !mem_we && $stable(accumulator))
        else $error("skipped instruction took effect");
    a_copy_load: assert property (exec && instr_op == exec_pkg::OP_COPY_SKIP |=>
        accumulator == $past(mem_rdata) && $stable(zero_flag)) else $error("copy wrong");
    a_bit_flags: assert property (exec && instr_op == exec_pkg::OP_BIT_SKIP |=>
        $stable(zero_flag) && $stable(accumulator)) else $error("bit skip changed state");
    a_table_wait: assert property (
        exec && tbl |=> !instr_ready [*2] ##1 instr_ready && mem_we)
        else $error("table read timing wrong");
    a_final_page: assert property (exec && instr_op == exec_pkg::OP_TABLE_FINAL |=>
        prog_req && prog_addr == {5'h1F, $past(table_pointer_low)})
        else $error("final page addr");
    a_xor_acc: assert property (exec && instr_op == exec_pkg::OP_XOR_ACC |=>
        accumulator == $past(xor_m) && zero_flag == (accumulator == 8'h00)) else $error("xor acc");
    a_xor_mem: assert property (exec && instr_op == exec_pkg::OP_XOR_MEM |=>
        mem_we && mem_wdata == $past(xor_m) && zero_flag == (mem_wdata == 8'h00))
        else $error("xor mem");
    a_xor_imm: assert property (exec && instr_op == exec_pkg::OP_XOR_IMM |=>
        accumulator == $past(xor_i) && zero_flag == (accumulator == 8'h00)) else $error("xor imm");
    // Main scenarios reached
    c_skip_next: cover property (zskip ##1 take);
    c_table: cover property (exec && tbl);
    c_xor_mem: cover property (exec && instr_op == exec_pkg::OP_XOR_MEM);
endmodule : skip_table_xor_exec_props
bind skip_table_xor_exec skip_table_xor_exec_props props (.clk(clk), .rstn(rstn),
    .instr_valid(instr_valid), .instr_op(instr_op), .instr_bit(instr_bit),
    .instr_imm(instr_imm), .mem_rdata(mem_rdata),
    .table_pointer_low(table_pointer_low), .instr_ready(instr_ready), .prog_req(prog_req),
    .prog_addr(prog_addr), .mem_we(mem_we), .mem_wdata(mem_wdata), .accumulator(accumulator),
    .zero_flag(zero_flag));

// ===== testbench/mcu_skip_table_xor_exec_bench.sv
module mcu_skip_table_xor_exec_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rstn = 1'b0, instr_valid = 1'b0, has_high_ptr = 1'b0;
    exec_pkg::op_type instr_op = exec_pkg::OP_NOP;
    logic [2:0] instr_bit = 3'h0;
    logic [7:0] instr_imm = 8'h00, instr_addr = 8'h00, mem_rdata = 8'h00;
    logic [7:0] table_pointer_low = 8'h00, table_pointer_high = 8'h00;
    logic [15:0] prog_rdata = 16'h0000;
    logic prog_req, mem_we, instr_ready, pc_advance, zero_flag;
    logic [12:0] prog_addr;
    logic [7:0] mem_waddr, mem_wdata, accumulator, table_high_latch;
    logic [16:0] rq[$];  // Expected accumulator, zero flag, high latch per retire
    logic [15:0] wq[$];  // Expected write address and data
    logic [7:0] acc_m = 8'h00, table_high_latch_m = 8'h00;  // Reference state
    logic z_m = 1'b0, skip_m = 1'b0;
    int checked = 0, miscompares = 0;
    logic [16:0] ret_seen, ret_exp, wr_seen, wr_exp;  // Values handed to check
    skip_table_xor_exec DUT (.clk(clk), .rstn(rstn), .instr_valid(instr_valid),
        .instr_op(instr_op), .instr_bit(instr_bit), .instr_imm(instr_imm),
        .instr_addr(instr_addr), .has_high_ptr(has_high_ptr), .mem_rdata(mem_rdata),
        .table_pointer_low(table_pointer_low), .table_pointer_high(table_pointer_high),
        .prog_req(prog_req), .prog_addr(prog_addr), .prog_rdata(prog_rdata), .mem_we(mem_we),
        .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .instr_ready(instr_ready),
        .pc_advance(pc_advance), .accumulator(accumulator),
        .table_high_latch(table_high_latch), .zero_flag(zero_flag));
    always #2.5 clk = ~clk;
    // Program memory answers the cycle after a request
    always @(posedge clk) begin
        if (prog_req) prog_rdata <= {3'h0, prog_addr} ^ 16'hC33C;
    end
    task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Drive the given instruction with random operands, wait until taken, then update the reference
    task automatic issue(input logic [3:0] op, input logic [7:0] m);
        logic [7:0] a, imm, lo, hi;
        logic [2:0] b;
        logic hp;
        logic [12:0] pa;
        logic [15:0] w;
        int n;
        {a, imm, lo, hi} = $urandom;
        {b, hp} = 4'($urandom);
        instr_valid <= 1'b1;
        instr_op <= exec_pkg::op_type'(op);
        {instr_addr, mem_rdata, instr_imm, instr_bit} <= {a, m, imm, b};
        {table_pointer_low, table_pointer_high, has_high_ptr} <= {lo, hi, hp};
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!instr_ready && n < 20);
        @(posedge clk);
        if (skip_m) begin  // Dropped instruction retires with no effect
            skip_m = 1'b0;
        end else begin
            case (op)
                4'h1: acc_m = {m[3:0], m[7:4]};
                4'h2: skip_m = (m == 8'h00);
                4'h3: {acc_m, skip_m} = {m, m == 8'h00};
                4'h4: skip_m = !m[b];
                4'h5, 4'h6: begin  // Table reads
                    pa = hp ? {hi[4:0], lo} : {5'h00, lo};
                    if (op == 4'h6) pa = {5'h1F, lo};
                    w = {3'h0, pa} ^ 16'hC33C;
                    table_high_latch_m = w[15:8];
                    wq.push_back({a, w[7:0]});
                end
                4'h8: begin  // Result to memory
                    wq.push_back({a, acc_m ^ m});
                    z_m = ((acc_m ^ m) == 8'h00);
                end
                default: begin  // Result to accumulator
                    acc_m = acc_m ^ ((op == 4'h7) ? m : imm);
                    z_m = (acc_m == 8'h00);
                end
            endcase
        end
        rq.push_back({acc_m, z_m, table_high_latch_m});
    endtask : issue
    // Compare each retire and each write with the oldest note
    always @(negedge clk) begin
        if (rstn && pc_advance) begin
            ret_seen = {accumulator, zero_flag, table_high_latch};
            ret_exp = rq.size() ? rq.pop_front() : 'x;
            check("retire", ret_seen, ret_exp);
        end
        if (rstn && mem_we) begin
            wr_seen = {1'b0, mem_waddr, mem_wdata};
            wr_exp = wq.size() ? {1'b0, wq.pop_front()} : 'x;
            check("write", wr_seen, wr_exp);
        end
    end
    task automatic finish_test();
        miscompares += rq.size() + wq.size();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    initial begin
        void'($urandom(95));
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 400; i++) begin  // Each op first with zero, then random
            issue(i < 18 ? 4'(i % 9 + 1) : 4'($urandom_range(9, 1)),
                (i < 9 || $urandom_range(3, 0) == 0) ? 8'h00 : 8'($urandom));
        end
        instr_valid <= 1'b0;
        repeat (8) @(posedge clk);
        finish_test();
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (6000) @(posedge clk);
        miscompares++;
        finish_test();
    end
endmodule : mcu_skip_table_xor_exec_bench
